// ===== rtl/ssf_spi_slave.sv
// spi slave front end: instruction decode, verification byte, frame checks
`timescale 1ns/1ps

// Behaviour
// - slave only; master owns the serial clock, at most 5 MBaud
// - answer only with select low and chip address bits zero, zero
// - serial output high impedance within two clock cycles of select going high
// - instruction first, then data byte msb first either way
// - instruction: address bits 7..6, code 5..1, parity bit 0
// - select high returns the logic to waiting for an instruction
// - serial output high impedance while reset is low
// - supply monitor has no influence on the serial logic
// - verification byte goes out while the instruction comes in
// - verification byte: z, z, 1, 0, 1, 0, 1, error flag
// - serial input ignored after the instruction of a read
// - write or clear diagnostics: output low after verification byte
// - bits beyond the sixteenth of a frame are discarded
// - unused code or unfinished previous processing makes it invalid
// - falling edge count not 16 flags error, blocks write and clear
// - clock high at select release blocks a write
// - invalid instruction: no register change, send ff after verification
// - valid read code returns the register even with bad parity
// - valid write code sends 00; registers change only with good parity
// - error flag set after invalid access, held until sent, resets 0
// - output high impedance during the two address bits
// - shared select with 32-bit frames never activates this device
// - clear diagnostics code 11000 resets all five diagnostic registers
module ssf_spi_slave
  import ssf_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       sck_i,
  input  wire logic       ss_b_i,
  input  wire logic       si_i,
  input  wire logic       busy_i,
  input  wire logic [7:0] rd_data_i,
  output logic            so_o,
  output logic            so_oe_b_o,
  output logic [4:0]      rd_code_o,
  output logic            wr_stb_o,
  output ssf_wr_s         wr_o,
  output logic            diag_clr_o,
  output logic            prev_xfer_error_flag_o
);

  // pin synchronisers and edge history
  logic       sck_m_ff;
  logic       sck_q_ff;
  logic       sck_d_ff;
  logic       ss_m_ff;
  logic       ss_q_ff;
  logic       ss_d_ff;
  logic       si_m_ff;
  logic       si_q_ff;

  // frame state
  ssf_state_e state_ff;
  ssf_kind_e  kind_ff;
  logic [4:0] bit_cnt_ff;
  logic [15:0] rx_ff;
  logic [4:0] code_ff;
  logic       busy_cap_ff;
  logic       par_ok_ff;
  logic       ld_pend_ff;
  logic [7:0] data_out_ff;
  logic       err_cap_ff;
  logic       err_ff;
  logic       so_ff;
  logic       oe_b_ff;

  logic       sck_fall;
  logic       sck_rise;
  logic       ss_rise;
  logic       selected;
  logic       count_ok;
  logic       code_ok;
  logic       frame_bad;
  logic       apply_ok;
  logic [4:0] nxt_code;
  logic [15:0] tx_word;

  // two flops on every pin; only the second flop feeds logic; the serial
  // clock must stay below an eighth of the system clock
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sck_m_ff <= 1'b0;
      sck_q_ff <= 1'b0;
      ss_m_ff  <= 1'b1;
      ss_q_ff  <= 1'b1;
      si_m_ff  <= 1'b0;
      si_q_ff  <= 1'b0;
    end else begin
      sck_m_ff <= sck_i;
      sck_q_ff <= sck_m_ff;
      ss_m_ff  <= ss_b_i;
      ss_q_ff  <= ss_m_ff;
      si_m_ff  <= si_i;
      si_q_ff  <= si_m_ff;
    end
  end

  // previous samples for edge finding
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sck_d_ff <= 1'b0;
      ss_d_ff  <= 1'b1;
    end else begin
      sck_d_ff <= sck_q_ff;
      ss_d_ff  <= ss_q_ff;
    end
  end

  // edges only count while selected; input is sampled on the fall
  // a clock left running between frames is masked by the select gate
  assign sck_fall = sck_d_ff & ~sck_q_ff & ~ss_q_ff;
  assign sck_rise = ~sck_d_ff & sck_q_ff & ~ss_q_ff;
  assign ss_rise  = ~ss_d_ff & ss_q_ff;
  assign selected = (state_ff == ST_CODE) || (state_ff == ST_DATA);
  assign nxt_code = {rx_ff[3:0], si_q_ff};

  // frame checks judged at the release of select
  assign count_ok  = (bit_cnt_ff == FRAME_BITS);
  assign code_ok   = (kind_ff != KIND_NONE) && !busy_cap_ff;
  assign frame_bad = !code_ok || !count_ok || !par_ok_ff;
  assign apply_ok  = ss_rise && selected && !frame_bad;

  // falling edge counter, saturates so long frames stay long
  // a started 17th bit never falls while selected, so it is judged by level
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ss_q_ff) begin
      bit_cnt_ff <= 5'h00;
    end else if (sck_fall && bit_cnt_ff != CNT_MAX) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // receive shifter; stops after sixteen bits
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ss_q_ff) begin
      rx_ff <= 16'h0000;
    end else if (sck_fall && bit_cnt_ff < FRAME_BITS) begin
      rx_ff <= {rx_ff[14:0], si_q_ff};
    end
  end

  // frame sequencer; 32-bit frames of other chips stay ignored since
  // the address is only taken from the first two bits
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ss_q_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_ADDR;
        end
        ST_ADDR: begin
          if (sck_fall && bit_cnt_ff == ADDR_LAST) begin
            if ({rx_ff[0], si_q_ff} == CHIP_ADDR) begin
              state_ff <= ST_CODE;
            end else begin
              state_ff <= ST_IGNORE;
            end
          end
        end
        ST_CODE: begin
          if (sck_fall && bit_cnt_ff == PAR_BIT) begin
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          state_ff <= ST_DATA;
        end
        ST_IGNORE: begin
          state_ff <= ST_IGNORE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // code decode after the seventh bit; busy is frozen at that moment
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ss_q_ff) begin
      kind_ff     <= KIND_NONE;
      code_ff     <= 5'h00;
      busy_cap_ff <= 1'b0;
      ld_pend_ff  <= 1'b0;
    end else if (state_ff == ST_CODE && sck_fall && bit_cnt_ff == CODE_LAST) begin
      kind_ff     <= code_kind(nxt_code);
      code_ff     <= nxt_code;
      busy_cap_ff <= busy_i;
      ld_pend_ff  <= 1'b1;
    end else begin
      ld_pend_ff  <= 1'b0;
    end
  end

  // parity taken on the eighth bit
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ss_q_ff) begin
      par_ok_ff <= 1'b0;
    end else if (state_ff == ST_CODE && sck_fall && bit_cnt_ff == PAR_BIT) begin
      par_ok_ff <= ((^code_ff) == si_q_ff);
    end
  end

  // byte sent after verification; read data waits one cycle for the bank
  // busy or unused codes answer ff even when the code is a read
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ss_q_ff) begin
      data_out_ff <= DATA_INVALID;
    end else if (ld_pend_ff) begin
      if (!code_ok) begin
        data_out_ff <= DATA_INVALID;
      end else if (kind_ff == KIND_READ) begin
        data_out_ff <= rd_data_i;
      end else begin
        data_out_ff <= DATA_ZERO;
      end
    end
  end

  // error flag: set at release of a bad frame, cleared once sent;
  // the set wins if both land together
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      err_ff <= 1'b0;
    end else if (ss_rise && selected && frame_bad) begin
      err_ff <= 1'b1;
    end else if (state_ff == ST_CODE && sck_fall && bit_cnt_ff == PAR_BIT) begin
      err_ff <= 1'b0;
    end
  end

  // copy of the flag frozen for the frame being sent
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      err_cap_ff <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      err_cap_ff <= err_ff;
    end
  end

  // whole outgoing frame, msb first; top two cells never driven
  assign tx_word = {2'b00, VERIFY_PAT, err_cap_ff, data_out_ff};

  // output changes on rising edges, only once the address matched
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ss_q_ff) begin
      so_ff   <= 1'b0;
      oe_b_ff <= 1'b1;
    end else if (sck_rise && selected && bit_cnt_ff < FRAME_BITS) begin
      so_ff   <= tx_word[FRAME_TOP - bit_cnt_ff[3:0]];
      oe_b_ff <= 1'b0;
    end
  end

  // enable depends on reset, select and frame only
  // the select synchroniser keeps the output driven up to two cycles
  assign so_o      = so_ff;
  assign so_oe_b_o = oe_b_ff | ss_q_ff | ~rst_b_i;

  // register bank strobes at the release of a clean frame; a 17th
  // started bit shows as clock still high and blocks writes only
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wr_stb_o   <= 1'b0;
      diag_clr_o <= 1'b0;
      wr_o       <= '0;
    end else begin
      wr_stb_o   <= apply_ok && kind_ff == KIND_WRITE && !sck_q_ff;
      diag_clr_o <= apply_ok && kind_ff == KIND_CLEAR;
      if (apply_ok) begin
        wr_o <= '{code: code_ff, data: rx_ff[7:0]};
      end
    end
  end

  // read select held in a flop for the register bank
  assign rd_code_o              = code_ff;
  assign prev_xfer_error_flag_o = err_ff;

  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_TRI_SS: assert property (ss_q_ff |-> so_oe_b_o)
    else $error("output driven while deselected");
  // the reset check must stay live while reset is low
  AST_TRI_RST: assert property (@(posedge clock_i) disable iff (1'b0)
      !rst_b_i |-> so_oe_b_o)
    else $error("output driven during reset");
  AST_ADDR_TRI: assert property (state_ff == ST_ADDR |-> so_oe_b_o)
    else $error("output driven during address bits");
  AST_IGNORE: assert property (state_ff == ST_IGNORE |=> so_oe_b_o && !wr_stb_o)
    else $error("foreign frame answered");
  AST_IDLE: assert property (ss_q_ff |=> state_ff == ST_IDLE && bit_cnt_ff == 5'h00)
    else $error("logic not idle after deselect");
  AST_WR_COUNT: assert property (wr_stb_o |->
      $past(bit_cnt_ff) == FRAME_BITS && !$past(sck_q_ff))
    else $error("write applied on a bad frame length");
  AST_WR_PARITY: assert property (wr_stb_o |-> $past(par_ok_ff) && !$past(busy_cap_ff))
    else $error("write applied without good parity");
  AST_FLAG_SET: assert property (ss_rise && selected && frame_bad |=> err_ff [*2])
    else $error("error flag not held after bad frame");
  AST_VERIFY: assert property (sck_rise && selected && bit_cnt_ff == VERIFY_FIRST
      |=> so_ff == VERIFY_PAT[4] && !so_oe_b_o)
    else $error("verification pattern missing");
  AST_FILL_FF: assert property (sck_rise && state_ff == ST_DATA && !code_ok
      && bit_cnt_ff >= DATA_FIRST && bit_cnt_ff < FRAME_BITS |=> so_ff)
    else $error("invalid instruction not answered with ones");
  AST_RX_STOP: assert property (bit_cnt_ff >= FRAME_BITS && !ss_q_ff |=> $stable(rx_ff))
    else $error("bits beyond sixteen accepted");

  // data phase, strobe shape and flag life
  AST_FILL_ZERO: assert property (sck_rise && state_ff == ST_DATA && code_ok
      && kind_ff != KIND_READ && bit_cnt_ff >= DATA_FIRST
      && bit_cnt_ff < FRAME_BITS |=> !so_ff && !so_oe_b_o)
    else $error("write or clear data cells not driven low");
  AST_CLR_COUNT: assert property (diag_clr_o |->
      $past(bit_cnt_ff) == FRAME_BITS && $past(par_ok_ff))
    else $error("clear applied on a bad frame");
  AST_CLR_CODE: assert property (diag_clr_o |-> wr_o.code == CODE_CLR)
    else $error("clear strobe for another code");
  AST_STB_PULSE: assert property (wr_stb_o || diag_clr_o |=>
      !wr_stb_o && !diag_clr_o)
    else $error("strobe longer than one cycle");
  AST_FLAG_HOLD: assert property (err_ff && !(state_ff == ST_CODE && sck_fall
      && bit_cnt_ff == PAR_BIT) |=> err_ff)
    else $error("error flag dropped before it was sent");
  AST_FOREIGN: assert property (state_ff == ST_IGNORE |=> $stable(err_ff))
    else $error("foreign frame touched the error flag");

  COV_WRITE: cover property (wr_stb_o);
  COV_CLEAR: cover property (diag_clr_o);
  COV_READ: cover property (ss_rise && selected && kind_ff == KIND_READ);
  COV_ERROR: cover property (ss_rise && selected && frame_bad);
  COV_FOREIGN: cover property (ss_rise && state_ff == ST_IGNORE);

endmodule

// ===== rtl/ssf_pkg.sv
// constants, types and decoding for the spi slave command front end
package ssf_pkg;

  // instruction byte layout and frame bit positions
  localparam logic [1:0] CHIP_ADDR    = 2'h0;
  localparam logic [4:0] VERIFY_PAT   = 5'h15;
  localparam logic [4:0] ADDR_LAST    = 5'h01;
  localparam logic [4:0] VERIFY_FIRST = 5'h02;
  localparam logic [4:0] CODE_LAST    = 5'h06;
  localparam logic [4:0] PAR_BIT      = 5'h07;
  localparam logic [4:0] DATA_FIRST   = 5'h08;
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [4:0] CNT_MAX      = 5'h1f;
  localparam logic [3:0] FRAME_TOP    = 4'hf;

  // instruction code ranges
  localparam logic [4:0] RD_LAST   = 5'h0f;
  localparam logic [4:0] WR_FIRST  = 5'h11;
  localparam logic [4:0] WR_LAST   = 5'h17;
  localparam logic [4:0] CODE_CLR  = 5'h18;

  // fill bytes sent after the verification byte
  localparam logic [7:0] DATA_INVALID = 8'hff;
  localparam logic [7:0] DATA_ZERO    = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_CODE   = 3'b010,
    ST_DATA   = 3'b011,
    ST_IGNORE = 3'b100
  } ssf_state_e;

  typedef enum logic [1:0] {
    KIND_NONE  = 2'b00,
    KIND_READ  = 2'b01,
    KIND_WRITE = 2'b10,
    KIND_CLEAR = 2'b11
  } ssf_kind_e;

  typedef struct packed {
    logic [4:0] code;
    logic [7:0] data;
  } ssf_wr_s;

  // classify an instruction code; unused codes give none
  function automatic ssf_kind_e code_kind(input logic [4:0] c);
    if (c <= RD_LAST) begin
      return KIND_READ;
    end else if (c >= WR_FIRST && c <= WR_LAST) begin
      return KIND_WRITE;
    end else if (c == CODE_CLR) begin
      return KIND_CLEAR;
    end
    return KIND_NONE;
  endfunction

endpackage

// ===== dv/ssf_spi_master.sv
// spi master model that drives frames into the slave front end
`timescale 1ns/1ps
module ssf_spi_master (
  input  wire logic clock_i,
  input  wire logic so_i,
  input  wire logic so_oe_b_i,
  output logic      sck_o,
  output logic      ss_b_o,
  output logic      si_o
);
  // idle: clock parked low, select released
  initial begin
    sck_o  = 1'b0;
    ss_b_o = 1'b1;
    si_o   = 1'b0;
  end

  // half an 800 ns bit cell, slower than the 5 mbaud ceiling
  task automatic hold(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // msb first, shift on rise, read back just before the next rise
  task automatic xfer(input logic [31:0] tx, input int nclk, input bit hi_end,
                      output logic [15:0] rx, output logic [15:0] zm);
    rx = 16'h0000;
    zm = 16'h0000;
    ss_b_o = 1'b0;
    hold(4);
    for (int k = 0; k < nclk; k++) begin
      sck_o = 1'b1;
      si_o  = tx[31-k];
      hold(4);
      sck_o = 1'b0;
      hold(4);
      if (k < 16) begin
        rx[15-k] = so_oe_b_i ? ~so_i : so_i; // undriven line reads back inverted
        zm[15-k] = so_oe_b_i;
      end
    end
    // a started 17th bit leaves the clock high at release
    if (hi_end) begin
      sck_o = 1'b1;
    end
    hold(1);
    ss_b_o = 1'b1;
    si_o   = ~si_o; // released line never keeps a stale bit
    hold(1);
    sck_o = 1'b0;
    hold(8);
  endtask
endmodule

// ===== dv/ssf_spi_slave_test.sv
// self-checking bench for the spi slave command front end
`timescale 1ns/1ps
module ssf_spi_slave_test;
  import ssf_pkg::*;
  logic       clock_i, rst_b_i, sck_i, ss_b_i, si_i, busy_i, so_o, so_oe_b_o;
  logic       wr_stb_o, diag_clr_o, flag_o;
  logic [7:0] rd_data_i = 8'h00;
  logic [4:0] rd_code_o;
  ssf_wr_s    wr_o;
  int         errors, samples_checked, cycles, wr_cnt, clr_cnt;

  ssf_spi_slave i_ssf_spi_slave (.clock_i(clock_i), .rst_b_i(rst_b_i), .sck_i(sck_i),
    .ss_b_i(ss_b_i), .si_i(si_i), .busy_i(busy_i), .rd_data_i(rd_data_i), .so_o(so_o),
    .so_oe_b_o(so_oe_b_o), .rd_code_o(rd_code_o), .wr_stb_o(wr_stb_o), .wr_o(wr_o),
    .diag_clr_o(diag_clr_o), .prev_xfer_error_flag_o(flag_o));
  ssf_spi_master i_ssf_spi_master (.clock_i(clock_i), .so_i(so_o), .so_oe_b_i(so_oe_b_o),
    .sck_o(sck_i), .ss_b_o(ss_b_i), .si_o(si_i));

  // 100 ns clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // register bank stand-in: contents derived from the code asked for
  always @(negedge clock_i) rd_data_i <= {3'h5, rd_code_o};

  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // strobe counting and a hang guard well above the ~2500 cycle run
  always @(posedge clock_i) begin
    cycles++;
    if (wr_stb_o === 1'b1) wr_cnt++;
    if (diag_clr_o === 1'b1) clr_cnt++;
    if (cycles == 20000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // instruction byte, parity spoiled on request
  function automatic logic [7:0] ins(input logic [4:0] c, input bit ok);
    return {CHIP_ADDR, c, ^c ^ !ok};
  endfunction

  // addressed frame; the flag cell is only checked once it was clocked out
  task automatic frame(input logic [31:0] tx, input int nclk, input bit hi, input logic ef,
                       input logic [7:0] ed, input int ew, input int ec);
    logic [15:0] rx, zm;
    wr_cnt  = 0;
    clr_cnt = 0;
    i_ssf_spi_master.xfer(tx, nclk, hi, rx, zm);
    chk(zm, 16'hc000, "drive mask");
    if (nclk >= 8) chk({11'h0, rx[13:9]}, {11'h0, VERIFY_PAT}, "pattern");
    if (nclk >= 8) chk({15'h0, rx[8]}, {15'h0, ef}, "flag");
    if (nclk >= 16) chk({8'h0, rx[7:0]}, {8'h0, ed}, "data");
    chk(16'(wr_cnt), 16'(ew), "writes");
    chk(16'(clr_cnt), 16'(ec), "clears");
    if (ew > 0) chk({3'h0, wr_o}, {3'h0, tx[29:25], tx[23:16]}, "write word");
    chk({15'h0, so_oe_b_o}, 16'h0001, "released");
  endtask

  // frame for another chip: nothing may be driven or applied
  task automatic idle_frame(input logic [31:0] tx, input int nclk);
    logic [15:0] rx, zm;
    wr_cnt  = 0;
    clr_cnt = 0;
    i_ssf_spi_master.xfer(tx, nclk, 1'b0, rx, zm);
    chk(zm, 16'hffff, "foreign drive");
    chk(16'(wr_cnt + clr_cnt), 16'h0000, "foreign strobes");
  endtask

  task automatic do_reset();
    rst_b_i = 1'b0;
    repeat (4) @(negedge clock_i);
    chk({14'h0, so_oe_b_o, flag_o}, 16'h0002, "reset state");
    rst_b_i = 1'b1;
    repeat (4) @(negedge clock_i);
  endtask

  // main sequence
  initial begin
    busy_i = 1'b0;
    do_reset();
    frame({ins(5'h07, 1), 8'h55, 16'h0}, 16, 0, 0, 8'ha7, 0, 0);
    frame({ins(5'h03, 0), 8'h00, 16'h0}, 16, 0, 0, 8'ha3, 0, 0);
    frame({ins(5'h12, 1), 8'h3c, 16'h0}, 16, 0, 1, 8'h00, 1, 0);
    frame({ins(5'h12, 0), 8'h3c, 16'h0}, 16, 0, 0, 8'h00, 0, 0);
    frame({ins(5'h10, 1), 8'h3c, 16'h0}, 16, 0, 1, 8'hff, 0, 0);
    idle_frame({8'h40, 8'h00, 16'h0}, 16);
    idle_frame({8'hc0, 8'h00, ins(5'h12, 1), 8'h3c}, 32);
    frame({ins(5'h18, 1), 8'h00, 16'h0}, 16, 0, 1, 8'h00, 0, 1);
    frame({ins(5'h12, 1), 8'h3c, 16'h0}, 15, 0, 0, 8'h00, 0, 0);
    frame({ins(5'h12, 1), 8'h3c, 16'h0}, 17, 0, 1, 8'h00, 0, 0);
    frame({ins(5'h12, 1), 8'h3c, 16'h0}, 16, 1, 1, 8'h00, 0, 0);
    frame({ins(5'h18, 1), 8'h00, 16'h0}, 16, 1, 0, 8'h00, 0, 1);
    busy_i = 1'b1;
    frame({ins(5'h12, 1), 8'h3c, 16'h0}, 16, 0, 0, 8'hff, 0, 0);
    busy_i = 1'b0;
    frame({ins(5'h07, 1), 8'h00, 16'h0}, 16, 0, 1, 8'ha7, 0, 0);
    frame({ins(5'h07, 1), 8'h00, 16'h0}, 5, 0, 0, 8'h00, 0, 0);
    frame({ins(5'h1f, 1), 8'h3c, 16'h0}, 16, 0, 1, 8'hff, 0, 0);
    do_reset();
    frame({ins(5'h07, 1), 8'h00, 16'h0}, 16, 0, 0, 8'ha7, 0, 0);
    conclude();
  end
endmodule
